// [verilog/pasd_consts.vh]
`ifndef PASD_CONSTS_VH
`define PASD_CONSTS_VH
// ----------------------------------------
// register map
// ----------------------------------------
`define PASD_ADDR_W          1
`define PASD_OFS_SHUTDOWN    1'h0
`define PASD_OFS_RESTART     1'h1
`define PASD_SHUTDOWN_RESET  8'h00
`define PASD_RESTART_RESET   8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define PASD_FLAG_BIT        7
`define PASD_SRC_HI          6
`define PASD_SRC_LO          4
`define PASD_AC_HI           3
`define PASD_AC_LO           2
`define PASD_BD_HI           1
`define PASD_BD_LO           0
`define PASD_RSEN_BIT        7
`define PASD_DC_HI           6
`define PASD_DC_LO           0
`define PASD_DC_W            7
// ----------------------------------------
// shutdown level encodings
// ----------------------------------------
`define PASD_LVL_ZERO        2'h0
`define PASD_LVL_ONE         2'h1
`define PASD_LVL_FLOAT_BIT   1
`endif

// [verilog/pasd_shutdown_dead_band.v]
`timescale 1ns/10ps
`include "pasd_consts.vh"
module pasd_shutdown_dead_band (
   input  wire                    sys_clk,
   input  wire                    reset,
   input  wire [`PASD_ADDR_W-1:0] reg_addr,
   input  wire [7:0]              reg_wdata,
   input  wire                    reg_wr,
   input  wire                    reg_rd,
   output reg  [7:0]              reg_rdata,
   input  wire                    instr_clk_en,
   input  wire                    period_start,
   input  wire [3:0]              pwm_raw,
   input  wire [3:0]              pwm_active_high,
   input  wire                    fault_input_pin,
   input  wire                    comparator_one_output,
   input  wire                    comparator_two_output,
   output reg  [3:0]              pwm_out,
   output reg  [3:0]              pwm_out_oe_n,
   output wire                    shutdown_event_flag
);

   // ----------------------------------------
   // pin synchronisers, three stages
   // ----------------------------------------
   reg  [2:0] flt_sync_q;
   reg  [2:0] c1_sync_q;
   reg  [2:0] c2_sync_q;
   reg        flt_q;
   reg        c1_q;
   reg        c2_q;

   always @(posedge sys_clk) begin
      if (reset) begin
         flt_sync_q <= 3'h7;
         c1_sync_q  <= 3'h0;
         c2_sync_q  <= 3'h0;
         flt_q      <= 1'b1;
         c1_q       <= 1'b0;
         c2_q       <= 1'b0;
      end else begin
         flt_sync_q <= {flt_sync_q[1:0], fault_input_pin};
         c1_sync_q  <= {c1_sync_q[1:0], comparator_one_output};
         c2_sync_q  <= {c2_sync_q[1:0], comparator_two_output};
         // a change counts only once stages two and three agree
         if (flt_sync_q[1] == flt_sync_q[2]) begin
            flt_q <= flt_sync_q[2];
         end
         if (c1_sync_q[1] == c1_sync_q[2]) begin
            c1_q <= c1_sync_q[2];
         end
         if (c2_sync_q[1] == c2_sync_q[2]) begin
            c2_q <= c2_sync_q[2];
         end
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg                   flag_q;
   reg [2:0]             src_q;
   reg [1:0]             ac_lvl_q;
   reg [1:0]             bd_lvl_q;
   reg                   rsen_q;
   reg [`PASD_DC_W-1:0]  dc_q;
   reg                   hold_q;

   // ----------------------------------------
   // shutdown source decode
   // ----------------------------------------
   reg cmp_hit;
   reg src_active;

   always @* begin
      case (src_q[1:0])
         2'h1:    cmp_hit = c1_q;
         2'h2:    cmp_hit = c2_q;
         2'h3:    cmp_hit = c1_q | c2_q;
         default: cmp_hit = 1'b0;
      endcase
      // fault pin is active low
      src_active = cmp_hit | (src_q[2] & ~flt_q);
   end

   wire wr_shut = reg_wr && (reg_addr == `PASD_OFS_SHUTDOWN);
   wire wr_rst  = reg_wr && (reg_addr == `PASD_OFS_RESTART);

   always @(posedge sys_clk) begin
      if (reset) begin
         flag_q   <= 1'b0;
         src_q    <= 3'h0;
         ac_lvl_q <= 2'h0;
         bd_lvl_q <= 2'h0;
         rsen_q   <= 1'b0;
         dc_q     <= {`PASD_DC_W{1'b0}};
      end else begin
         if (wr_shut) begin
            src_q    <= reg_wdata[`PASD_SRC_HI:`PASD_SRC_LO];
            ac_lvl_q <= reg_wdata[`PASD_AC_HI:`PASD_AC_LO];
            bd_lvl_q <= reg_wdata[`PASD_BD_HI:`PASD_BD_LO];
         end
         if (wr_rst) begin
            rsen_q <= reg_wdata[`PASD_RSEN_BIT];
            dc_q   <= reg_wdata[`PASD_DC_HI:`PASD_DC_LO];
         end
         // set wins over any clear in the same cycle
         if (src_active) begin
            flag_q <= 1'b1;
         end else if (rsen_q) begin
            flag_q <= 1'b0;
         end else if (wr_shut) begin
            flag_q <= reg_wdata[`PASD_FLAG_BIT];
         end
      end
   end

   assign shutdown_event_flag = flag_q;

   // outputs stay in shutdown until a period boundary follows the clear
   always @(posedge sys_clk) begin
      if (reset) begin
         hold_q <= 1'b0;
      end else if (flag_q) begin
         hold_q <= 1'b1;
      end else if (period_start) begin
         hold_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // register read, one cycle later
   // ----------------------------------------
   always @(posedge sys_clk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == `PASD_OFS_SHUTDOWN) begin
            reg_rdata <= {flag_q, src_q, ac_lvl_q, bd_lvl_q};
         end else begin
            reg_rdata <= {rsen_q, dc_q};
         end
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ----------------------------------------
   // per-output delay and shutdown drive
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_out
         reg [`PASD_DC_W-1:0] cnt_q;
         reg                  dly_q;
         wire                 act  = ~(pwm_raw[i] ^ pwm_active_high[i]);
         // a and c share one level field, b and d the other
         wire [1:0]           lvl  = (i == 0 || i == 2) ? ac_lvl_q : bd_lvl_q;
         wire                 idle = ~pwm_active_high[i];

         always @(posedge sys_clk) begin
            if (reset) begin
               cnt_q <= {`PASD_DC_W{1'b0}};
               dly_q <= 1'b0;
            end else if (!act) begin
               // going inactive is never delayed
               cnt_q <= {`PASD_DC_W{1'b0}};
               dly_q <= 1'b0;
            end else if (!dly_q) begin
               if (cnt_q >= dc_q) begin
                  dly_q <= 1'b1;
               end else if (instr_clk_en) begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
         end

         always @(posedge sys_clk) begin
            if (reset) begin
               pwm_out[i]      <= 1'b0;
               pwm_out_oe_n[i] <= 1'b1;
            end else if (hold_q || flag_q) begin
               pwm_out_oe_n[i] <= lvl[`PASD_LVL_FLOAT_BIT];
               pwm_out[i]      <= (lvl == `PASD_LVL_ONE);
            end else begin
               pwm_out_oe_n[i] <= 1'b0;
               pwm_out[i]      <= dly_q ? ~idle : idle;
            end
         end
      end
   endgenerate

endmodule

// [sim/pasd_bridge.sv]
`timescale 1ns/10ps
// ----
// half-bridge driver stage
// ----
module pasd_bridge (
   input  [3:0] pwm_out,
   input  [3:0] pwm_out_oe_n,
   input        overcurrent,
   output [3:0] gate,
   output       fault_n
);
   // floated pin: gate pull-down keeps the switch off
   assign gate = pwm_out & ~pwm_out_oe_n;
   // open-drain fault line, pulled up when quiet
   assign fault_n = ~overcurrent;
endmodule

// [sim/pasd_asserts.sv]
`timescale 1ns/10ps
module pasd_asserts (
   input       sys_clk,
   input       reset,
   input       reg_addr,
   input [7:0] reg_wdata,
   input       reg_wr,
   input       reg_rd,
   input [7:0] reg_rdata,
   input       period_start,
   input [3:0] pwm_raw,
   input [3:0] pwm_active_high,
   input       fault_input_pin,
   input       comparator_one_output,
   input       comparator_two_output,
   input [3:0] pwm_out,
   input [3:0] pwm_out_oe_n,
   input       shutdown_event_flag
);
   // ----
   // shadow of the written fields
   // ----
   logic [7:0] cfg_q, rs_q;
   wire flg = shutdown_event_flag;
   // raw pins: sync lag is absorbed by the repeat counts
   wire trip = cfg_q[6] & ~fault_input_pin | cfg_q[4] & comparator_one_output
      | cfg_q[5] & comparator_two_output;
   wire [3:0] lvl_oe = {2{cfg_q[1], cfg_q[3]}};
   wire [3:0] lvl_o = {2{cfg_q[1:0] == 2'h1, cfg_q[3:2] == 2'h1}};
   always @(posedge sys_clk) begin
      if (reset || reg_wr && !reg_addr)
         cfg_q <= reset ? 8'h00 : reg_wdata;
      if (reset || reg_wr && reg_addr)
         rs_q <= reset ? 8'h00 : reg_wdata;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_flag_read: assert property ($past(reg_rd) && !$past(reg_addr) |-> reg_rdata[7] == $past(flg))
      else $error("flag readback wrong");
   a_src_off: assert property (cfg_q[6:4] == 3'h0 && !flg && !reg_wr |=> !flg)
      else $error("flag set with source off");
   a_trip_sets: assert property ((trip && $stable(cfg_q)) [*7] |-> flg)
      else $error("selected source did not set flag");
   a_auto_clear: assert property ((rs_q[7] && !trip && !reg_wr) [*8] |-> !flg)
      else $error("flag not cleared by itself");
   a_manual_hold: assert property (!rs_q[7] && flg && !reg_wr |=> flg)
      else $error("flag cleared without software");
   a_shut_level: assert property ($past(flg) && $stable(cfg_q) |-> pwm_out == lvl_o && pwm_out_oe_n == lvl_oe)
      else $error("shutdown level wrong");
   a_hold_period: assert property ($fell(flg) && !period_start |-> ##2 pwm_out_oe_n == lvl_oe)
      else $error("resumed before period start");
   a_fall_fast: assert property ($fell(pwm_raw[0]) && pwm_active_high[0] && !flg && !pwm_out_oe_n[0] |-> ##2 !pwm_out[0])
      else $error("inactive edge delayed");
   c_trip: cover property ($rose(flg));
   c_hold: cover property ($fell(flg) ##1 period_start);
   c_fall: cover property ($fell(pwm_raw[0]) && !flg);
endmodule
bind pasd_shutdown_dead_band pasd_asserts u_chk (.*);

// [sim/pwm_auto_shutdown_dead_band_test.sv]
`timescale 1ns/10ps
module pwm_auto_shutdown_dead_band_test;
   logic       sys_clk = 0, reset = 1, reg_addr = 0, reg_wr = 0, reg_rd = 0;
   logic       period_start = 0, c1 = 0, c2 = 0, oc = 0, fault_n, flag;
   logic [7:0] reg_wdata = 8'h00, reg_rdata;
   logic [3:0] pwm_raw = 4'h0, pwm_out, pwm_out_oe_n, pcnt_q = 4'h0;
   int         error_cnt = 0, checked = 0, n0, n1, s;
   pasd_shutdown_dead_band dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .instr_clk_en(1'b1), .period_start(period_start), .pwm_raw(pwm_raw),
      .pwm_active_high(4'hf), .fault_input_pin(fault_n), .comparator_one_output(c1),
      .comparator_two_output(c2), .pwm_out(pwm_out), .pwm_out_oe_n(pwm_out_oe_n),
      .shutdown_event_flag(flag));
   pasd_bridge u_br (.pwm_out(pwm_out), .pwm_out_oe_n(pwm_out_oe_n), .overcurrent(oc),
      .gate(), .fault_n(fault_n));
   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      pcnt_q <= pcnt_q + 4'h1;
      period_start <= pcnt_q == 4'hf;
   end
   // ----
   // bus and compare tasks
   // ----
   task automatic test_done;
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   task automatic src(input logic o, input logic a, input logic b);
      @(posedge sys_clk);
      oc <= o;
      c1 <= a;
      c2 <= b;
      repeat (8) @(posedge sys_clk);
   endtask
   // edges from active request to active pin, then a two-cycle fall
   task automatic meas(input logic [6:0] d, output int n);
      wr(1'b1, {1'b0, d});
      repeat (20) @(posedge sys_clk);
      pwm_raw <= 4'hf;
      n = 0;
      while (pwm_out !== 4'hf) begin
         @(posedge sys_clk);
         #1 n++;
         if (n > 300) begin
            error_cnt++;
            test_done;
         end
      end
      @(posedge sys_clk);
      pwm_raw <= 4'h0;
      // no count on the way down: same two flops as a zero-delay rise
      repeat (2) @(posedge sys_clk);
      #1 chk({pwm_out_oe_n, pwm_out}, 8'h00);
   endtask
   // ----
   // sequence
   // ----
   initial begin
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      rd(1'b0, 8'h00);
      rd(1'b1, 8'h00);
      for (s = 1; s < 8; s++) begin
         wr(1'b0, {1'b0, s[2:0], 4'h6});
         src(s[2], s[0], s[1] & ~s[0]);
         wr(1'b0, {1'b0, s[2:0], 4'h6});
         rd(1'b0, {1'b1, s[2:0], 4'h6});
         chk({pwm_out_oe_n, pwm_out}, 8'ha5);
         src(1'b0, 1'b0, 1'b0);
         rd(1'b0, {1'b1, s[2:0], 4'h6});
         wr(1'b0, {1'b0, s[2:0], 4'h6});
         rd(1'b0, {1'b0, s[2:0], 4'h6});
      end
      wr(1'b0, 8'h00);
      src(1'b1, 1'b1, 1'b1);
      rd(1'b0, 8'h00);
      src(1'b0, 1'b0, 1'b0);
      wr(1'b1, 8'h80);
      wr(1'b0, 8'h40);
      src(1'b1, 1'b0, 1'b0);
      rd(1'b0, 8'hc0);
      src(1'b0, 1'b0, 1'b0);
      rd(1'b0, 8'h40);
      meas(7'h00, n0);
      meas(7'h7f, n1);
      chk(8'(n1 - n0), 8'h7f);
      test_done;
   end
endmodule
